// file: design/pulse_out_pkg.sv
package pulse_out_pkg;

    // ------------------------------------------------------------
    // Register byte addresses
    // ------------------------------------------------------------
    localparam logic [7:0] ADDR_CTRL    = 8'h00;
    localparam logic [7:0] ADDR_FREQ    = 8'h04;
    localparam logic [7:0] ADDR_TARGET  = 8'h08;
    localparam logic [7:0] ADDR_TOTAL   = 8'h0C;
    localparam logic [7:0] ADDR_STATUS  = 8'h10;
    localparam logic [7:0] ADDR_W1_BASE = 8'h20;
    localparam logic [7:0] ADDR_P1_BASE = 8'h40;
    localparam logic [7:0] ADDR_W2_BASE = 8'h60;
    localparam logic [7:0] ADDR_P2_BASE = 8'h80;
    localparam logic [7:0] ADDR_TBL_MSK = 8'hE0;

    // ------------------------------------------------------------
    // Control register fields
    // ------------------------------------------------------------
    localparam int CTRL_MODE_LO = 0;
    localparam int CTRL_MODE_HI = 2;
    localparam int CTRL_EN1     = 3;
    localparam int CTRL_EN2     = 4;
    localparam int CTRL_SEL1_LO = 5;
    localparam int CTRL_SEL1_HI = 7;
    localparam int CTRL_SEL2_LO = 8;
    localparam int CTRL_SEL2_HI = 10;
    localparam int CTRL_PORT    = 11;
    localparam int CTRL_W       = 12;

    // ------------------------------------------------------------
    // Operating modes
    // ------------------------------------------------------------
    localparam logic [2:0] MODE_PWM       = 3'h1;
    localparam logic [2:0] MODE_TRAIN     = 3'h2;
    localparam logic [2:0] MODE_PWM_JOINT = 3'h3;
    localparam logic [2:0] MODE_TRAIN_DUO = 3'h4;
    localparam logic [2:0] MODE_TRAIN_AB  = 3'h5;

    // ------------------------------------------------------------
    // Limits and timing
    // ------------------------------------------------------------
    localparam int          PRESETS   = 8;
    localparam int          VAL_W     = 15;
    localparam int          FREQ_W    = 16;
    localparam logic [15:0] FREQ_MAX  = 16'h03E8;
    localparam logic [15:0] FREQ_MIN  = 16'h0001;
    localparam int          CLK_HZ    = 10000000;
    localparam int          TICK_MS   = 1;
    localparam int          MS_CYCLES = CLK_HZ / 1000 * TICK_MS;
    localparam int          QTR_STEP  = CLK_HZ / 4;
    localparam int          ACC_W     = 24;
    localparam logic [31:0] RST_ZERO  = 32'h0000_0000;

endpackage

// file: design/pwm_channel.sv
`timescale 1ns/100ps
module pwm_channel (
    input  wire logic        pclk,
    input  wire logic        presetn,
    input  wire logic        run,
    input  wire logic        ms_tick,
    input  wire logic [14:0] width,
    input  wire logic [14:0] period,
    output logic             wave
);

    logic [14:0] cnt_q, cnt_d;
    logic [14:0] cur_w_q, cur_w_d;
    logic [14:0] cur_p_q, cur_p_d;
    logic        wave_q, wave_d;

    // ------------------------------------------------------------
    // Period counter, presets latched at each period start
    // ------------------------------------------------------------
    always_comb begin
        cnt_d   = cnt_q;
        cur_w_d = cur_w_q;
        cur_p_d = cur_p_q;
        wave_d  = wave_q;
        if (!run) begin
            cnt_d  = '0;
            wave_d = 1'b0;
        end else if (ms_tick) begin
            if (cnt_q == '0) begin
                cur_w_d = width;
                cur_p_d = (period == '0) ? 15'h0001 : period;
                wave_d  = (width != '0);
                cnt_d   = (period > 15'h0001) ? 15'h0001 : 15'h0000;
            end else begin
                wave_d = (cnt_q < cur_w_q);
                cnt_d  = (cnt_q + 15'h0001 >= cur_p_q) ? 15'h0000 : cnt_q + 15'h0001;
            end
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cnt_q   <= '0;
            cur_w_q <= '0;
            cur_p_q <= 15'h0001;
            wave_q  <= 1'b0;
        end else begin
            cnt_q   <= cnt_d;
            cur_w_q <= cur_w_d;
            cur_p_q <= cur_p_d;
            wave_q  <= wave_d;
        end
    end

    assign wave = wave_q;

endmodule

// file: design/pulse_output.sv
`timescale 1ns/100ps
// Notes on behaviour
// - Five modes: per-channel PWM, single train, joint PWM, dual train, AB train.
// - Eight width/period pairs; select bits plus one pick pair; disabled shows 0, off.
// - Widths 0 to 32767 ms, periods 1 to 32767 ms.
// - Selected class 1 to 8 readable while PWM runs.
// - Mode 1: channel one drives port one, channel two drives port two.
// - Mode 3: same PWM wave on both ports from one preset set.
// - Mode 2: train on one selected port.
// - Train frequency 1 to 1000 Hz from a live register value.
// - Frequency above 1000 clamps to 1000 Hz.
// - Frequency changes follow on the fly without stopping.
// - Target 0 to 32767; output stops once emitted count reaches target.
// - Target zero runs forever until enable drops.
// - Re-enable emits target again; total keeps counting, cleared only by reset.
// - Cumulative pulse total readable in its own register.
// - Mode 4: identical train on both ports.
// - Mode 5: port one phase A leads port two phase B.
module pulse_output #(
    parameter int MS_CYCLES = pulse_out_pkg::MS_CYCLES
) (
    input  wire logic        pclk,
    input  wire logic        presetn,
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [7:0]  paddr,
    input  wire logic [31:0] pwdata,
    output logic [31:0]      prdata,
    output logic             pready,
    output logic             pslverr,
    output logic             output_port_one,
    output logic             output_port_two
);

    localparam int VW = pulse_out_pkg::VAL_W;
    localparam int NP = pulse_out_pkg::PRESETS;

    // ------------------------------------------------------------
    // Register storage
    // ------------------------------------------------------------
    logic [pulse_out_pkg::CTRL_W-1:0] ctrl_q, ctrl_d;
    logic [pulse_out_pkg::FREQ_W-1:0] train_frequency_q, train_frequency_d;
    logic [VW-1:0]                    train_target_count_q, train_target_count_d;
    logic [VW-1:0]                    w1_q [NP], w1_d [NP];
    logic [VW-1:0]                    p1_q [NP], p1_d [NP];
    logic [VW-1:0]                    w2_q [NP], w2_d [NP];
    logic [VW-1:0]                    p2_q [NP], p2_d [NP];
    logic [31:0]                      prdata_q, prdata_d;
    logic                             err_q, err_d;
    logic [31:0]                      cumulative_pulse_total_q, cumulative_pulse_total_d;

    logic        wr_en, setup;
    logic [2:0]  mode;
    logic        en1, en2, pwm_mode, train_mode;
    logic [2:0]  sel1, sel2;
    logic [3:0]  class1, class2;
    logic [2:0]  tidx;
    logic        tbl_hit, done_q, done_d;

    assign setup   = psel && !penable;
    assign wr_en   = psel && penable && pwrite;
    assign pready  = 1'b1;
    assign pslverr = err_q;
    assign prdata  = prdata_q;
    assign tidx    = paddr[4:2];
    assign tbl_hit = (paddr[7:5] != 3'h0) && (paddr[7:5] <= 3'h4);

    assign mode       = ctrl_q[pulse_out_pkg::CTRL_MODE_HI:pulse_out_pkg::CTRL_MODE_LO];
    assign en1        = ctrl_q[pulse_out_pkg::CTRL_EN1];
    assign en2        = ctrl_q[pulse_out_pkg::CTRL_EN2];
    assign sel1       = ctrl_q[pulse_out_pkg::CTRL_SEL1_HI:pulse_out_pkg::CTRL_SEL1_LO];
    assign sel2       = ctrl_q[pulse_out_pkg::CTRL_SEL2_HI:pulse_out_pkg::CTRL_SEL2_LO];
    assign pwm_mode   = (mode == pulse_out_pkg::MODE_PWM)
                     || (mode == pulse_out_pkg::MODE_PWM_JOINT);
    assign train_mode = (mode == pulse_out_pkg::MODE_TRAIN)
                     || (mode == pulse_out_pkg::MODE_TRAIN_DUO)
                     || (mode == pulse_out_pkg::MODE_TRAIN_AB);

    // Class display: select plus one while its PWM channel runs, else zero
    assign class1 = (pwm_mode && en1) ? {1'b0, sel1} + 4'h1 : 4'h0;
    assign class2 = (mode == pulse_out_pkg::MODE_PWM && en2) ? {1'b0, sel2} + 4'h1
                                                             : 4'h0;

    // ------------------------------------------------------------
    // APB writes and registered read data
    // ------------------------------------------------------------
    always_comb begin
        ctrl_d               = ctrl_q;
        train_frequency_d    = train_frequency_q;
        train_target_count_d = train_target_count_q;
        w1_d = w1_q;
        p1_d = p1_q;
        w2_d = w2_q;
        p2_d = p2_q;
        prdata_d = prdata_q;
        err_d    = 1'b0;
        if (wr_en) begin
            unique case (paddr[7:5])
                3'h1: w1_d[tidx] = pwdata[VW-1:0];
                3'h2: p1_d[tidx] = pwdata[VW-1:0];
                3'h3: w2_d[tidx] = pwdata[VW-1:0];
                3'h4: p2_d[tidx] = pwdata[VW-1:0];
                default: begin
                    if (paddr == pulse_out_pkg::ADDR_CTRL)
                        ctrl_d = pwdata[pulse_out_pkg::CTRL_W-1:0];
                    if (paddr == pulse_out_pkg::ADDR_FREQ)
                        train_frequency_d = pwdata[pulse_out_pkg::FREQ_W-1:0];
                    if (paddr == pulse_out_pkg::ADDR_TARGET)
                        train_target_count_d = pwdata[VW-1:0];
                end
            endcase
        end
        if (setup) begin
            err_d    = 1'b0;
            prdata_d = pulse_out_pkg::RST_ZERO;
            unique case (paddr[7:5])
                3'h1: prdata_d = {17'h0, w1_q[tidx]};
                3'h2: prdata_d = {17'h0, p1_q[tidx]};
                3'h3: prdata_d = {17'h0, w2_q[tidx]};
                3'h4: prdata_d = {17'h0, p2_q[tidx]};
                default: begin
                    unique case (paddr)
                        pulse_out_pkg::ADDR_CTRL:   prdata_d = {20'h0, ctrl_q};
                        pulse_out_pkg::ADDR_FREQ:   prdata_d = {16'h0, train_frequency_q};
                        pulse_out_pkg::ADDR_TARGET: prdata_d = {17'h0, train_target_count_q};
                        pulse_out_pkg::ADDR_TOTAL:  prdata_d = cumulative_pulse_total_q;
                        pulse_out_pkg::ADDR_STATUS: prdata_d = {21'h0, done_q,
                            output_port_two, output_port_one, class2, class1};
                        default:                    err_d = 1'b1;
                    endcase
                end
            endcase
            if (paddr[1:0] != 2'h0 || !tbl_hit && paddr[7:5] != 3'h0)
                err_d = 1'b1;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ctrl_q               <= '0;
            train_frequency_q    <= pulse_out_pkg::FREQ_MIN;
            train_target_count_q <= '0;
            w1_q     <= '{default: '0};
            p1_q     <= '{default: 15'h0001};
            w2_q     <= '{default: '0};
            p2_q     <= '{default: 15'h0001};
            prdata_q <= pulse_out_pkg::RST_ZERO;
            err_q    <= 1'b0;
        end else begin
            ctrl_q               <= ctrl_d;
            train_frequency_q    <= train_frequency_d;
            train_target_count_q <= train_target_count_d;
            w1_q     <= w1_d;
            p1_q     <= p1_d;
            w2_q     <= w2_d;
            p2_q     <= p2_d;
            prdata_q <= prdata_d;
            err_q    <= err_d;
        end
    end

    // ------------------------------------------------------------
    // Millisecond tick
    // ------------------------------------------------------------
    logic [15:0] ms_cnt_q, ms_cnt_d;
    logic        ms_tick;

    always_comb begin
        ms_tick  = (ms_cnt_q == 16'(MS_CYCLES - 1));
        ms_cnt_d = ms_tick ? 16'h0000 : ms_cnt_q + 16'h0001;
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn)
            ms_cnt_q <= '0;
        else
            ms_cnt_q <= ms_cnt_d;
    end

    // ------------------------------------------------------------
    // Two PWM channels, presets picked by select bits
    // ------------------------------------------------------------
    logic [1:0] pwm_wave;
    logic [1:0] pwm_run;

    assign pwm_run[0] = pwm_mode && en1;
    assign pwm_run[1] = (mode == pulse_out_pkg::MODE_PWM) && en2;

    generate
        for (genvar c = 0; c < 2; c++) begin : g_chan
            pwm_channel u_chan (
                .pclk    (pclk),
                .presetn (presetn),
                .run     (pwm_run[c]),
                .ms_tick (ms_tick),
                .width   ((c == 0) ? w1_q[sel1] : w2_q[sel2]),
                .period  ((c == 0) ? p1_q[sel1] : p2_q[sel2]),
                .wave    (pwm_wave[c])
            );
        end
    endgenerate

    // ------------------------------------------------------------
    // Pulse train: quarter-phase accumulator
    // ------------------------------------------------------------
    logic [pulse_out_pkg::ACC_W-1:0] acc_q, acc_d, acc_sum;
    logic [1:0]                      phase_q, phase_d;
    logic [VW-1:0]                   emitted_q, emitted_d;
    logic [15:0]                     f_eff;
    logic                            train_run, qtick, phase_a, phase_b;

    assign train_run = train_mode && en1 && !done_q;
    assign f_eff = (train_frequency_q > pulse_out_pkg::FREQ_MAX) ? pulse_out_pkg::FREQ_MAX
                 : (train_frequency_q < pulse_out_pkg::FREQ_MIN) ? pulse_out_pkg::FREQ_MIN
                 : train_frequency_q;
    assign phase_a = train_run && !phase_q[1];
    assign phase_b = train_run && (phase_q == 2'h1 || phase_q == 2'h2);

    always_comb begin
        acc_sum   = acc_q + pulse_out_pkg::ACC_W'(f_eff);
        qtick     = acc_sum >= pulse_out_pkg::ACC_W'(pulse_out_pkg::QTR_STEP);
        acc_d     = acc_q;
        phase_d   = phase_q;
        emitted_d = emitted_q;
        done_d    = done_q;
        cumulative_pulse_total_d = cumulative_pulse_total_q;
        if (!(train_mode && en1)) begin
            acc_d     = '0;
            phase_d   = '0;
            emitted_d = '0;
            done_d    = 1'b0;
        end else if (train_run) begin
            acc_d = qtick ? acc_sum - pulse_out_pkg::ACC_W'(pulse_out_pkg::QTR_STEP) : acc_sum;
            if (qtick) begin
                phase_d = phase_q + 2'h1;
                if (phase_q == 2'h0) begin
                    emitted_d = emitted_q + 15'h0001;
                    cumulative_pulse_total_d = cumulative_pulse_total_q + 32'h0000_0001;
                end
                if (phase_q == 2'h3 && train_target_count_q != '0
                    && emitted_q >= train_target_count_q)
                    done_d = 1'b1;
            end
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            acc_q     <= '0;
            phase_q   <= '0;
            emitted_q <= '0;
            done_q    <= 1'b0;
            cumulative_pulse_total_q <= pulse_out_pkg::RST_ZERO;
        end else begin
            acc_q     <= acc_d;
            phase_q   <= phase_d;
            emitted_q <= emitted_d;
            done_q    <= done_d;
            cumulative_pulse_total_q <= cumulative_pulse_total_d;
        end
    end

    // ------------------------------------------------------------
    // Output routing per mode
    // ------------------------------------------------------------
    logic out1_q, out1_d, out2_q, out2_d;

    always_comb begin
        out1_d = 1'b0;
        out2_d = 1'b0;
        unique case (mode)
            pulse_out_pkg::MODE_PWM: begin
                out1_d = pwm_wave[0] && en1;
                out2_d = pwm_wave[1] && en2;
            end
            pulse_out_pkg::MODE_PWM_JOINT: begin
                out1_d = pwm_wave[0] && en1;
                out2_d = pwm_wave[0] && en1;
            end
            pulse_out_pkg::MODE_TRAIN: begin
                out1_d = phase_a && !ctrl_q[pulse_out_pkg::CTRL_PORT];
                out2_d = phase_a && ctrl_q[pulse_out_pkg::CTRL_PORT];
            end
            pulse_out_pkg::MODE_TRAIN_DUO: begin
                out1_d = phase_a;
                out2_d = phase_a;
            end
            pulse_out_pkg::MODE_TRAIN_AB: begin
                out1_d = phase_a;
                out2_d = phase_b;
            end
            default: begin
                out1_d = 1'b0;
                out2_d = 1'b0;
            end
        endcase
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            out1_q <= 1'b0;
            out2_q <= 1'b0;
        end else begin
            out1_q <= out1_d;
            out2_q <= out2_d;
        end
    end

    assign output_port_one = out1_q;
    assign output_port_two = out2_q;

    // ------------------------------------------------------------
    // Assertions
    // ------------------------------------------------------------
    sequence a_rise_s;
        $rose(phase_a);
    endsequence

    off_when_disabled_a: assert property (@(posedge pclk) disable iff (!presetn)
        !en1 && !en2 |=> !output_port_one && !output_port_two)
        else $error("output high while disabled");
    class_zero_off_a: assert property (@(posedge pclk) disable iff (!presetn)
        !en1 |-> class1 == 4'h0)
        else $error("class not zero while disabled");
    class_range_a: assert property (@(posedge pclk) disable iff (!presetn)
        pwm_mode && en1 |-> class1 == {1'b0, sel1} + 4'h1)
        else $error("class does not follow select");
    freq_clamp_a: assert property (@(posedge pclk) disable iff (!presetn)
        train_frequency_q > pulse_out_pkg::FREQ_MAX |-> f_eff == pulse_out_pkg::FREQ_MAX)
        else $error("frequency not clamped");
    joint_same_a: assert property (@(posedge pclk) disable iff (!presetn)
        mode == pulse_out_pkg::MODE_PWM_JOINT && $past(mode) == mode
        |-> output_port_one == output_port_two)
        else $error("joint outputs differ");
    train_stop_a: assert property (@(posedge pclk) disable iff (!presetn)
        done_q |=> !output_port_one && !output_port_two)
        else $error("train runs after target");
    total_step_a: assert property (@(posedge pclk) disable iff (!presetn)
        ##1 (cumulative_pulse_total_q == $past(cumulative_pulse_total_q)
          || cumulative_pulse_total_q == $past(cumulative_pulse_total_q) + 32'h1))
        else $error("total jumped");
    phase_lead_a: assert property (@(posedge pclk) disable iff (!presetn)
        a_rise_s |-> !phase_b)
        else $error("phase B not lagging");
    single_port_a: assert property (@(posedge pclk) disable iff (!presetn)
        mode == pulse_out_pkg::MODE_TRAIN && !ctrl_q[pulse_out_pkg::CTRL_PORT]
        && $past(ctrl_q) == ctrl_q |=> !output_port_two)
        else $error("second port driven in single train");

endmodule

// file: testbench/load_model.sv
`timescale 1ns/100ps
// ------------------------------------------------------------
// Loads on the two transistor outputs
// ------------------------------------------------------------
module load_model (
    input  wire logic        pclk,
    input  wire logic        presetn,
    input  wire logic        port_one,
    input  wire logic        port_two,
    output logic [15:0]      rises_one,
    output logic [15:0]      rises_two,
    output logic [15:0]      b_lags
);
    logic one_q;
    logic two_q;

    // Count rising edges; a B rise under a high A means A led
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            one_q     <= 1'b0;
            two_q     <= 1'b0;
            rises_one <= 16'h0000;
            rises_two <= 16'h0000;
            b_lags    <= 16'h0000;
        end else begin
            one_q     <= port_one;
            two_q     <= port_two;
            rises_one <= rises_one + 16'(port_one & ~one_q);
            rises_two <= rises_two + 16'(port_two & ~two_q);
            b_lags    <= b_lags + 16'(port_two & ~two_q & one_q);
        end
    end
endmodule

// file: testbench/tb_pulse_output.sv
`timescale 1ns/100ps
`define CHK(a, b) begin compares++; if ((a) !== (b)) begin miscompares++; \
$display("[FAIL] %0t got %h exp %h", $time, (a), (b)); end end
// ------------------------------------------------------------
// Bench for the pulse output block
// ------------------------------------------------------------
module tb_pulse_output;
    localparam logic [7:0] CTL = pulse_out_pkg::ADDR_CTRL;
    localparam logic [7:0] STS = pulse_out_pkg::ADDR_STATUS;
    localparam logic [7:0] TOT = pulse_out_pkg::ADDR_TOTAL;
    logic        pclk = 1'b0;
    logic        presetn = 1'b0;
    logic        psel = 1'b0;
    logic        penable = 1'b0;
    logic        pwrite = 1'b0;
    logic [7:0]  paddr = 8'h00;
    logic [31:0] pwdata = 32'h0;
    logic [31:0] prdata;
    logic        pready;
    logic        pslverr;
    logic        out1;
    logic        out2;
    logic [15:0] r1, r2, lag, base1, base2, base_lag;
    logic [31:0] rd;
    logic        er;
    time         t0;
    int          miscompares = 0;
    int          compares = 0;

    // Clock at 10 MHz
    always #50 pclk = ~pclk;

    pulse_output #(.MS_CYCLES(10)) dut (.pclk(pclk), .presetn(presetn), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
        .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .output_port_one(out1), .output_port_two(out2));
    load_model load (.pclk(pclk), .presetn(presetn), .port_one(out1), .port_two(out2),
        .rises_one(r1), .rises_two(r2), .b_lags(lag));

    // Verdict and end of run
    task automatic test_done();
        $display("compares %0d miscompares %0d", compares, miscompares);
        if (miscompares == 0 && compares > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask
    task automatic fail_out();
        miscompares++;
        test_done();
    endtask
    // One APB transfer, held until pready is seen
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        int n;
        @(posedge pclk);
        psel   <= 1'b1;
        pwrite <= w;
        paddr  <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        n = 0;
        do begin
            @(posedge pclk);
            n++;
        end while (pready !== 1'b1 && n < 50);
        if (pready !== 1'b1) fail_out();
        rd = prdata;
        er = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        apb(1'b1, a, d);
    endtask
    task automatic rchk(input logic [7:0] a, input logic [31:0] e);
        apb(1'b0, a, 32'h0);
        `CHK(rd, e)
    endtask
    // High-cycle counts over ten whole periods
    task automatic duty(output int h1, output int h2, output int ne);
        h1 = 0;
        h2 = 0;
        ne = 0;
        repeat (400) begin
            @(posedge pclk);
            h1 += int'(out1 === 1'b1);
            h2 += int'(out2 === 1'b1);
            ne += int'(out1 !== out2);
        end
    endtask
    task automatic off();
        wr(CTL, 32'h0);
        repeat (2) @(posedge pclk);
        `CHK({out1, out2}, 2'b00)
        rchk(STS, 32'h0);
    endtask
    task automatic train(input logic [31:0] c, input logic [31:0] f, input logic [31:0] t);
        int n;
        wr(pulse_out_pkg::ADDR_FREQ, f);
        wr(pulse_out_pkg::ADDR_TARGET, t);
        {base1, base2, base_lag} = {r1, r2, lag};
        wr(CTL, c);
        t0 = $time;
        n = 0;
        do begin
            apb(1'b0, STS, 32'h0);
            n++;
        end while (rd[10] !== 1'b1 && n < 15000);
        if (rd[10] !== 1'b1) fail_out();
    endtask
    task automatic t_regs();
        rchk(pulse_out_pkg::ADDR_FREQ, 32'h1);
        rchk(TOT, 32'h0);
        apb(1'b0, 8'h14, 32'h0);
        `CHK(er, 1'b1)
        wr(pulse_out_pkg::ADDR_P1_BASE + 8'h1C, 32'h7FFF);
        rchk(pulse_out_pkg::ADDR_P1_BASE + 8'h1C, 32'h7FFF);
        $display("regs done");
    endtask
    task automatic t_pwm();
        int h1, h2, ne;
        wr(pulse_out_pkg::ADDR_W1_BASE + 8'h08, 32'h2);
        wr(pulse_out_pkg::ADDR_P1_BASE + 8'h08, 32'h4);
        wr(pulse_out_pkg::ADDR_W2_BASE, 32'h1);
        wr(pulse_out_pkg::ADDR_P2_BASE, 32'h4);
        wr(CTL, 32'h59);
        repeat (100) @(posedge pclk);
        duty(h1, h2, ne);
        `CHK(h1, 200)
        `CHK(h2, 100)
        apb(1'b0, STS, 32'h0);
        `CHK(rd[7:0], 8'h13)
        off();
        $display("pwm done");
    endtask
    task automatic t_joint();
        int h1, h2, ne;
        wr(pulse_out_pkg::ADDR_W1_BASE + 8'h1C, 32'h3);
        wr(pulse_out_pkg::ADDR_P1_BASE + 8'h1C, 32'h4);
        wr(CTL, 32'hEB);
        repeat (100) @(posedge pclk);
        duty(h1, h2, ne);
        `CHK(h1, 300)
        `CHK(ne, 0)
        apb(1'b0, STS, 32'h0);
        `CHK(rd[3:0], 4'h8)
        off();
        $display("joint done");
    endtask
    task automatic t_single();
        time el;
        train(32'h80A, 32'h7D0, 32'h2);
        el = ($time - t0) / 100;
        `CHK(el >= 19000 && el <= 23000, 1'b1)
        `CHK(r2 - base2, 16'h0002)
        `CHK(r1 - base1, 16'h0000)
        rchk(TOT, 32'h2);
        off();
        $display("single done");
    endtask
    task automatic t_duo();
        train(32'h0C, 32'h3E8, 32'h1);
        `CHK(r1 - base1, 16'h0001)
        `CHK(r2 - base2, 16'h0001)
        `CHK(lag - base_lag, 16'h0000)
        rchk(TOT, 32'h3);
        off();
        $display("duo done");
    endtask
    task automatic t_ab();
        train(32'h0D, 32'h3E8, 32'h1);
        `CHK(lag - base_lag, 16'h0001)
        `CHK(r2 - base2, 16'h0001)
        rchk(TOT, 32'h4);
        off();
        $display("ab done");
    endtask
    task automatic t_free();
        wr(pulse_out_pkg::ADDR_TARGET, 32'h0);
        base1 = r1;
        wr(CTL, 32'h0A);
        repeat (11000) @(posedge pclk);
        apb(1'b0, STS, 32'h0);
        `CHK(rd[10], 1'b0)
        `CHK(r1 - base1 >= 16'h0002, 1'b1)
        // Halve the rate while running: at most two rises in 30000 cycles
        wr(pulse_out_pkg::ADDR_FREQ, 32'h1F4);
        base1 = r1;
        repeat (30000) @(posedge pclk);
        `CHK(r1 - base1 <= 16'h0002, 1'b1)
        `CHK(r1 - base1 >= 16'h0001, 1'b1)
        off();
        $display("free done");
    endtask

    // Reset, then the scenarios in turn
    initial begin
        repeat (6) @(posedge pclk);
        presetn <= 1'b1;
        t_regs();
        t_pwm();
        t_joint();
        t_single();
        t_duo();
        t_ab();
        t_free();
        test_done();
    end
endmodule
